// >>> npic_pkg.sv
package npic_pkg;
    // vector space
    localparam int NPIC_NVEC = 13;
    localparam int NPIC_NEXT = 3;
    localparam int NPIC_EXT_FIRST = 2;
    // vector addresses
    localparam logic [15:0] NPIC_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] NPIC_VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] NPIC_VEC_TOP = 16'hFFFA;
    // register byte offsets
    localparam logic [7:0] NPIC_OFF_ISPR0 = 8'h00;
    localparam logic [7:0] NPIC_OFF_ISPR1 = 8'h04;
    localparam logic [7:0] NPIC_OFF_ISPR2 = 8'h08;
    localparam logic [7:0] NPIC_OFF_ISPR3 = 8'h0C;
    localparam logic [7:0] NPIC_OFF_EXT_INT_SENSITIVITY_REG = 8'h10;
    localparam logic [7:0] NPIC_OFF_PINSEL = 8'h14;
    localparam logic [7:0] NPIC_OFF_CTRL = 8'h18;
    localparam logic [7:0] NPIC_OFF_STAT = 8'h1C;
    // reset values
    localparam logic [1:0] NPIC_PRIO_RST = 2'h3;
    localparam logic [5:0] NPIC_EXT_INT_SENSITIVITY_REG_RST = 6'h00;
    localparam logic [11:0] NPIC_PINSEL_RST = 12'h000;
    localparam logic NPIC_NESTED_RST = 1'b1;
    // priority bit pair codes
    localparam logic [1:0] NPIC_LVL0_CODE = 2'h2;
    localparam logic [1:0] NPIC_LVL3_CODE = 2'h3;
    // sensitivity codes
    localparam logic [1:0] NPIC_SENS_LOW = 2'h0;
    localparam logic [1:0] NPIC_SENS_RISE = 2'h1;
    localparam logic [1:0] NPIC_SENS_FALL = 2'h2;
    // status field positions
    localparam int NPIC_STAT_TRAP = 16;
    localparam int NPIC_STAT_PRIO = 18;
    localparam int NPIC_STAT_DEPTH = 20;

    typedef enum logic [1:0] {S_RSTVEC, S_IDLE, S_STACK, S_VECTOR} npic_state_t;
endpackage

// >>> npic_ctrl.sv
////////////////////////////////////////////////////////////////////////////////
//
// Design decisions made here: the APB register port and the register offsets.
module npic_ctrl import npic_pkg::*; #(
    parameter int PINS_PER = 4,
    parameter logic [NPIC_NVEC-1:0] HALT_WAKE = 13'h041D
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // interrupt sources
    input wire logic [NPIC_NEXT*PINS_PER-1:0] EXT_PIN,
    input wire logic [NPIC_NVEC-1:0] PER_FLAG,
    input wire logic [NPIC_NVEC-1:0] PER_EN,
    input wire logic [NPIC_NVEC-1:0] PER_CLR,
    // cpu sequencer side
    input wire logic CPU_INSN_END,
    input wire logic CPU_TRAP,
    input wire logic CPU_STACK_DONE,
    input wire logic CPU_RETURN_FROM_INTERRUPT,
    input wire logic CPU_CC_WR,
    input wire logic [1:0] CPU_CC_PRIO,
    input wire logic CPU_HALT,
    input wire logic CPU_WAIT,
    output logic STACK_PUSH,
    output logic VEC_LOAD,
    output logic [15:0] VEC_ADDR,
    output logic PRIO_BIT_HIGH,
    output logic PRIO_BIT_LOW,
    output logic WAKE
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    npic_state_t state_q, state_d;
    logic [1:0] ispr_q [NPIC_NVEC];
    logic [5:0] ext_int_sensitivity_reg_q;
    logic [NPIC_NEXT*PINS_PER-1:0] pinsel_q;
    logic nested_q;
    logic [NPIC_NVEC-1:0] pend_q, pend_d;
    logic [NPIC_NEXT-1:0] line_prev_q;
    logic trap_pend_q;
    logic halt_exit_q;
    logic [1:0] prio_q;
    logic [2:0] depth_q;
    logic [3:0] sel_idx_q;
    logic sel_nmi_q;
    logic push_q, load_q, wake_q, pready_q, slverr_q;
    logic [15:0] vaddr_q;
    logic [31:0] prdata_q;

    // level of a bit pair: 10->0, 01->1, 00->2, 11->3
    function automatic logic [1:0] lvl(input logic [1:0] b);
        lvl = {~(b[1] ^ b[0]), b[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic setup_acc = PSEL & PENABLE & ~pready_q;
    wire logic done_acc = PSEL & PENABLE & pready_q;
    wire logic wr_en = done_acc & PWRITE;
    wire logic hit_ispr0 = PADDR == NPIC_OFF_ISPR0;
    wire logic hit_ispr1 = PADDR == NPIC_OFF_ISPR1;
    wire logic hit_ispr2 = PADDR == NPIC_OFF_ISPR2;
    wire logic hit_ispr3 = PADDR == NPIC_OFF_ISPR3;
    wire logic hit_ext_int_sensitivity_reg = PADDR == NPIC_OFF_EXT_INT_SENSITIVITY_REG;
    wire logic hit_pinsel = PADDR == NPIC_OFF_PINSEL;
    wire logic hit_ctrl = PADDR == NPIC_OFF_CTRL;
    wire logic hit_stat = PADDR == NPIC_OFF_STAT;
    wire logic hit_rw = hit_ispr0 | hit_ispr1 | hit_ispr2 | hit_ispr3 | hit_ext_int_sensitivity_reg
                        | hit_pinsel | hit_ctrl;
    wire logic bad_acc = ~(hit_rw | (hit_stat & ~PWRITE));
    wire logic [31:0] ispr_rd [4];
    wire logic [31:0] stat_rd;

    // read views of the priority registers, unused pairs read as ones
    assign ispr_rd[0] = {24'h000000, ispr_q[3], ispr_q[2], ispr_q[1], ispr_q[0]};
    assign ispr_rd[1] = {24'h000000, ispr_q[7], ispr_q[6], ispr_q[5], ispr_q[4]};
    assign ispr_rd[2] = {24'h000000, ispr_q[11], ispr_q[10], ispr_q[9], ispr_q[8]};
    assign ispr_rd[3] = {24'h000000, 6'h3F, ispr_q[12]};
    assign stat_rd = {9'h000, depth_q, prio_q, 1'b0, trap_pend_q, 3'h0, pend_q};

    wire logic [31:0] rd_mux = hit_ispr0 ? ispr_rd[0] :
                               hit_ispr1 ? ispr_rd[1] :
                               hit_ispr2 ? ispr_rd[2] :
                               hit_ispr3 ? ispr_rd[3] :
                               hit_ext_int_sensitivity_reg ? {26'h0000000, ext_int_sensitivity_reg_q} :
                               hit_pinsel ? {20'h00000, pinsel_q} :
                               hit_ctrl ? {31'h00000000, nested_q} :
                               hit_stat ? stat_rd : 32'h00000000;

    // byte that holds pair i in a priority write
    function automatic logic ispr_wr_hit(input int i);
        ispr_wr_hit = (i < 4) ? hit_ispr0 : (i < 8) ? hit_ispr1 :
                      (i < 12) ? hit_ispr2 : hit_ispr3;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb response, one wait state then pready
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup_acc;
            slverr_q <= setup_acc & bad_acc;
            if (setup_acc) begin
                prdata_q <= (PWRITE || bad_acc) ? 32'h00000000 : rd_mux;
            end
        end
    end

    // priority pairs, a level 0 code leaves the pair unchanged
    for (genvar i = 0; i < NPIC_NVEC; i++) begin : g_ispr
        wire logic [1:0] wpair = PWDATA[2*(i%4)+:2];
        always_ff @(posedge MCLK or negedge RESET_N) begin
            if (!RESET_N) begin
                ispr_q[i] <= NPIC_PRIO_RST;
            end else if (wr_en && ispr_wr_hit(i) && wpair != NPIC_LVL0_CODE) begin
                ispr_q[i] <= wpair;
            end
        end
    end

    // control registers
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_int_sensitivity_reg_q <= NPIC_EXT_INT_SENSITIVITY_REG_RST;
            pinsel_q <= NPIC_PINSEL_RST;
            nested_q <= NPIC_NESTED_RST;
        end else if (wr_en) begin
            if (hit_ext_int_sensitivity_reg) begin
                ext_int_sensitivity_reg_q <= PWDATA[5:0];
            end
            if (hit_pinsel) begin
                pinsel_q <= PWDATA[NPIC_NEXT*PINS_PER-1:0];
            end
            if (hit_ctrl) begin
                nested_q <= PWDATA[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external lines: OR of selected pins, edge or level per line
    logic [NPIC_NEXT-1:0] line, ext_edge, ext_level, ext_edge_mode;
    for (genvar g = 0; g < NPIC_NEXT; g++) begin : g_ext
        wire logic [1:0] sens = ext_int_sensitivity_reg_q[2*g+:2];
        wire logic rise = line[g] & ~line_prev_q[g];
        wire logic fall = ~line[g] & line_prev_q[g];
        assign line[g] = |(EXT_PIN[g*PINS_PER+:PINS_PER]
                           & pinsel_q[g*PINS_PER+:PINS_PER]);
        assign ext_edge_mode[g] = sens != NPIC_SENS_LOW;
        assign ext_level[g] = (sens == NPIC_SENS_LOW) & ~line[g]
                              & (|pinsel_q[g*PINS_PER+:PINS_PER]);
        assign ext_edge[g] = (sens == NPIC_SENS_RISE) ? rise :
                             (sens == NPIC_SENS_FALL) ? fall :
                             (sens == NPIC_SENS_LOW) ? 1'b0 : (rise | fall);
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending latches: set wins over clear
    logic [NPIC_NVEC-1:0] set_v, clr_v, edge_vec, level_vec, req_v;
    wire logic entry = state_q == S_VECTOR;
    always_comb begin
        set_v = PER_FLAG & PER_EN;
        clr_v = PER_CLR;
        edge_vec = '0;
        level_vec = '0;
        for (int g = 0; g < NPIC_NEXT; g++) begin
            set_v[NPIC_EXT_FIRST+g] = set_v[NPIC_EXT_FIRST+g] | ext_edge[g];
            edge_vec[NPIC_EXT_FIRST+g] = ext_edge_mode[g];
            level_vec[NPIC_EXT_FIRST+g] = ext_level[g];
        end
        if (entry && !sel_nmi_q && edge_vec[sel_idx_q]) begin
            clr_v[sel_idx_q] = 1'b1;
        end
        pend_d = (pend_q & ~clr_v) | set_v;
        req_v = pend_q | level_vec;
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbitration
    logic [NPIC_NVEC-1:0] cand;
    logic win_valid;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;
    wire logic block_all = ~nested_q & (depth_q != 3'h0);
    always_comb begin
        cand = req_v & (halt_exit_q ? HALT_WAKE : {NPIC_NVEC{1'b1}});
        win_valid = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        for (int i = NPIC_NVEC - 1; i >= 0; i--) begin
            if (cand[i] && !block_all && lvl(ispr_q[i]) > lvl(prio_q)
                && (!win_valid || lvl(ispr_q[i]) >= win_lvl)) begin
                win_valid = 1'b1;
                win_idx = 4'(i);
                win_lvl = lvl(ispr_q[i]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // entry sequencer
    wire logic take = CPU_INSN_END & (trap_pend_q | win_valid);
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_RSTVEC: state_d = S_IDLE;
            S_IDLE: begin
                if (take) begin
                    state_d = S_STACK;
                end
            end
            S_STACK: begin
                if (CPU_STACK_DONE) begin
                    state_d = S_VECTOR;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= S_RSTVEC;
            sel_idx_q <= 4'h0;
            sel_nmi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == S_IDLE && take) begin
                sel_nmi_q <= trap_pend_q;
                sel_idx_q <= win_idx;
            end
        end
    end

    // sequencer outputs, reset vector skips stacking
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            push_q <= 1'b0;
            load_q <= 1'b0;
            vaddr_q <= NPIC_VEC_RESET;
        end else begin
            push_q <= state_q == S_IDLE && take;
            load_q <= state_d == S_VECTOR || state_q == S_RSTVEC;
            if (state_q == S_RSTVEC) begin
                vaddr_q <= NPIC_VEC_RESET;
            end else if (state_d == S_VECTOR) begin
                vaddr_q <= sel_nmi_q ? NPIC_VEC_TRAP : NPIC_VEC_TOP - {11'h000, sel_idx_q, 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current level, nesting depth, trap and halt tracking
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prio_q <= NPIC_LVL3_CODE;
            depth_q <= 3'h0;
            trap_pend_q <= 1'b0;
            halt_exit_q <= 1'b0;
            pend_q <= '0;
            line_prev_q <= '0;
        end else begin
            pend_q <= pend_d;
            line_prev_q <= line;
            if (entry) begin
                prio_q <= sel_nmi_q ? NPIC_LVL3_CODE : ispr_q[sel_idx_q];
            end else if (CPU_RETURN_FROM_INTERRUPT || CPU_CC_WR) begin
                prio_q <= CPU_CC_PRIO;
            end
            if (entry && !CPU_RETURN_FROM_INTERRUPT) begin
                depth_q <= depth_q + 3'h1;
            end else if (CPU_RETURN_FROM_INTERRUPT && !entry && depth_q != 3'h0) begin
                depth_q <= depth_q - 3'h1;
            end
            // trap set wins over its own clear
            trap_pend_q <= CPU_TRAP | (trap_pend_q & ~(entry & sel_nmi_q));
            if (CPU_HALT && wake_q) begin
                halt_exit_q <= 1'b1;
            end else if (entry) begin
                halt_exit_q <= 1'b0;
            end
        end
    end

    // wake: halt by capable sources and trap, wait by any source
    wire logic wake_d = (CPU_HALT & ((|(req_v & HALT_WAKE)) | trap_pend_q))
                        | (CPU_WAIT & ((|req_v) | trap_pend_q));
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = slverr_q;
    assign STACK_PUSH = push_q;
    assign VEC_LOAD = load_q;
    assign VEC_ADDR = vaddr_q;
    assign PRIO_BIT_HIGH = prio_q[1];
    assign PRIO_BIT_LOW = prio_q[0];
    assign WAKE = wake_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    chk_entry_boundary: assert property ($rose(push_q) |-> $past(CPU_INSN_END))
        else $error("entry started mid instruction");
    chk_push_before_vec: assert property ($rose(push_q) |-> ##1 !load_q)
        else $error("vector loaded without stacking");
    chk_vec_after_stack: assert property (state_q == S_STACK && CPU_STACK_DONE
        |=> load_q ##1 !load_q)
        else $error("vector load missing after stack");
    chk_prio_from_ispr: assert property (entry && !sel_nmi_q
        |=> prio_q == $past(ispr_q[sel_idx_q]))
        else $error("priority bits not loaded from vector level");
    chk_nmi_level3: assert property (entry && sel_nmi_q |=> prio_q == NPIC_LVL3_CODE
        && vaddr_q == NPIC_VEC_TRAP)
        else $error("trap entry not at level 3");
    chk_return_from_interrupt_restore: assert property (CPU_RETURN_FROM_INTERRUPT && !entry
        |=> prio_q == $past(CPU_CC_PRIO))
        else $error("return did not restore level");
    chk_reset_vector: assert property (state_q == S_RSTVEC |=> load_q
        && vaddr_q == NPIC_VEC_RESET && prio_q == NPIC_LVL3_CODE)
        else $error("reset vector not taken at level 3");
    chk_level0_kept: assert property (wr_en && hit_ispr0 && PWDATA[1:0] == NPIC_LVL0_CODE
        |=> ispr_q[0] == $past(ispr_q[0]))
        else $error("level 0 write changed a pair");
    chk_concurrent_hold: assert property (state_q == S_IDLE && block_all && !trap_pend_q
        |=> !push_q)
        else $error("concurrent mode preempted a routine");
    chk_halt_trap_wake: assert property (CPU_HALT && trap_pend_q |=> wake_q)
        else $error("trap did not wake halt");
    chk_wait_wake: assert property (CPU_WAIT && (|req_v) |=> wake_q)
        else $error("pending source did not wake wait");

    cov_nested_entry: cover property (depth_q == 3'h1 && entry);
    cov_trap_entry: cover property (entry && sel_nmi_q);
    cov_halt_exit: cover property (halt_exit_q && entry);
    cov_level0_write: cover property (wr_en && hit_ispr1 && PWDATA[1:0] == NPIC_LVL0_CODE);
endmodule // npic_ctrl

// >>> npic_cpu_model.sv
module npic_cpu_model (
    // clock
    input wire logic mclk,
    // controller requests
    input wire logic stack_push,
    input wire logic wake,
    input wire logic slow,
    // sequencer strobes
    output logic insn_end,
    output logic trap,
    output logic stack_done,
    output logic return_from_interrupt,
    output logic cc_wr,
    output logic [1:0] cc_prio,
    output logic halt,
    output logic wait_m,
    // push count
    output int pushes
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // idle levels at time zero
    initial begin
        {insn_end, trap, stack_done, return_from_interrupt, cc_wr, halt, wait_m} = '0;
        cc_prio = 2'h3;
        pushes = 0;
        cnt = 0;
    end

    // boundaries only while running; stacking answered fast or slow
    always @(posedge mclk) begin
        insn_end <= !halt && !wait_m && !insn_end;
        stack_done <= 1'b0;
        if (stack_push) begin
            cnt <= slow ? 4 : 1;
            pushes <= pushes + 1;
        end else if (cnt == 1) begin
            stack_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
        if (wake) begin
            halt <= 1'b0;
            wait_m <= 1'b0;
        end
    end

    // condition code write or return, one-cycle strobe
    task do_cc(input logic is_ret, input logic [1:0] p);
        @(posedge mclk);
        if (is_ret) return_from_interrupt <= 1'b1;
        else cc_wr <= 1'b1;
        cc_prio <= p;
        @(posedge mclk);
        return_from_interrupt <= 1'b0;
        cc_wr <= 1'b0;
        cc_prio <= ~p;
    endtask

    // trap instruction executed
    task do_trap;
        @(posedge mclk);
        trap <= 1'b1;
        @(posedge mclk);
        trap <= 1'b0;
    endtask

    // enter halt or wait
    task do_sleep(input logic h);
        @(posedge mclk);
        if (h) halt <= 1'b1;
        else wait_m <= 1'b1;
    endtask
endmodule // npic_cpu_model

// >>> tb_npic_ctrl.sv
module tb_npic_ctrl import npic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] ext_pin;
    logic [12:0] per_flag, per_en, per_clr;
    logic ins, trp, sdone, return_from_interrupt, ccwr, halt, waitm, push, vload, ph, pl, wake;
    logic [1:0] ccp;
    logic [15:0] vaddr;
    int pushes, mismatches, comparisons;

    // design and core model
    npic_ctrl DUT (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_PIN(ext_pin), .PER_FLAG(per_flag), .PER_EN(per_en),
        .PER_CLR(per_clr), .CPU_INSN_END(ins), .CPU_TRAP(trp), .CPU_STACK_DONE(sdone),
        .CPU_RETURN_FROM_INTERRUPT(return_from_interrupt), .CPU_CC_WR(ccwr), .CPU_CC_PRIO(ccp), .CPU_HALT(halt),
        .CPU_WAIT(waitm), .STACK_PUSH(push), .VEC_LOAD(vload), .VEC_ADDR(vaddr),
        .PRIO_BIT_HIGH(ph), .PRIO_BIT_LOW(pl), .WAKE(wake));
    npic_cpu_model cpu (.mclk(mclk), .stack_push(push), .wake(wake), .slow(slow),
        .insn_end(ins), .trap(trp), .stack_done(sdone), .return_from_interrupt(return_from_interrupt), .cc_wr(ccwr),
        .cc_prio(ccp), .halt(halt), .wait_m(waitm), .pushes(pushes));

    // clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task test_done;
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0 ] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // apb transfer, read data taken at the pready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // pready is read as it stood at this edge, before the design updates it
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            $display("[ERR] pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait for a vector load, then check address, level and stacking
    task entry(input string what, input logic [15:0] a, input logic [1:0] lv);
        int n, p0;
        n = 0;
        p0 = pushes;
        @(negedge mclk);
        while (vload !== 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        chk(what, {16'h0, a}, {16'h0, vaddr});
        @(negedge mclk);
        chk("prio bits", {30'h0, lv}, {30'h0, ph, pl});
        chk("pushes", 32'h1, 32'(pushes - p0));
    endtask

    task no_entry(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(negedge mclk);
            if (vload !== 1'b0) seen++;
        end
        chk("no entry", 32'h0, 32'(seen));
    endtask

    task wake_up(input int n);
        repeat (n) @(negedge mclk) if (wake === 1'b1) break;
        chk("wake", 32'h1, {31'h0, wake});
    endtask

    // software clears the flag, then the clearing sequence ends
    task drop(input int v);
        @(posedge mclk);
        per_flag[v] <= 1'b0;
        @(posedge mclk);
        per_clr[v] <= 1'b1;
        @(posedge mclk);
        per_clr[v] <= 1'b0;
    endtask

    task t_regs;
        apb(0, NPIC_OFF_ISPR0, 0);
        chk("ispr0", 32'hFF, rd & 32'hFF);
        apb(0, NPIC_OFF_ISPR3, 0);
        chk("ispr3", 32'hFF, rd & 32'hFF);
        apb(0, NPIC_OFF_EXT_INT_SENSITIVITY_REG, 0);
        chk("ext_int_sensitivity_reg", 32'h0, rd & 32'h3F);
        apb(0, NPIC_OFF_CTRL, 0);
        chk("ctrl", 32'h1, rd & 32'h1);
        apb(1, NPIC_OFF_STAT, 32'hFFFF);
        chk("stat write err", 32'h1, {31'h0, err});
        apb(0, 8'h20, 0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1, NPIC_OFF_ISPR0, 32'hCF);
        apb(1, NPIC_OFF_ISPR0, 32'h64);
        apb(0, NPIC_OFF_ISPR0, 0);
        chk("ispr0 keep", 32'h44, rd & 32'hFF);
    endtask

    task t_periph;
        apb(1, NPIC_OFF_ISPR1, 32'h17);
        apb(1, NPIC_OFF_ISPR2, 32'hF0);
        cpu.do_cc(0, 2'h2);
        @(posedge mclk);
        per_en[5] <= 1'b0;
        per_flag[5] <= 1'b1;
        no_entry(10);
        cpu.do_sleep(0);
        @(posedge mclk);
        per_en[5] <= 1'b1;
        wake_up(30);
        entry("vector 5", 16'hFFF0, 2'h1);
        drop(5);
        cpu.do_cc(1, 2'h2);
        cpu.do_cc(0, 2'h3);
        @(posedge mclk);
        per_flag[5] <= 1'b1;
        no_entry(8);
        drop(5);
        cpu.do_cc(0, 2'h2);
        no_entry(10);
    endtask

    task t_arb;
        slow <= 1'b1;
        @(posedge mclk);
        per_flag[7:6] <= 2'h3;
        entry("vector 7", 16'hFFEC, 2'h0);
        drop(7);
        no_entry(10);
        cpu.do_cc(1, 2'h2);
        entry("vector 6", 16'hFFEE, 2'h1);
        drop(6);
        cpu.do_cc(1, 2'h2);
        @(posedge mclk);
        per_flag[9:8] <= 2'h3;
        entry("vector 8", 16'hFFEA, 2'h0);
        drop(8);
        cpu.do_cc(1, 2'h2);
        entry("vector 9", 16'hFFE8, 2'h0);
        drop(9);
        cpu.do_cc(1, 2'h2);
        slow <= 1'b0;
    endtask

    task t_conc;
        apb(1, NPIC_OFF_CTRL, 0);
        per_flag[6] <= 1'b1;
        entry("vector 6", 16'hFFEE, 2'h1);
        drop(6);
        per_flag[7] <= 1'b1;
        no_entry(12);
        cpu.do_cc(1, 2'h2);
        entry("vector 7", 16'hFFEC, 2'h0);
        drop(7);
        cpu.do_cc(1, 2'h2);
        apb(1, NPIC_OFF_CTRL, 1);
    endtask

    task t_trap;
        cpu.do_cc(0, 2'h3);
        cpu.do_sleep(1);
        cpu.do_trap;
        wake_up(30);
        entry("trap", NPIC_VEC_TRAP, 2'h3);
        cpu.do_cc(1, 2'h2);
    endtask

    task t_ext;
        int seen;
        seen = 0;
        apb(1, NPIC_OFF_ISPR1, 32'h1F);
        apb(1, NPIC_OFF_EXT_INT_SENSITIVITY_REG, 32'h1);
        apb(1, NPIC_OFF_PINSEL, 32'h3);
        cpu.do_sleep(1);
        @(posedge mclk);
        per_flag[5] <= 1'b1;
        repeat (10) @(negedge mclk) if (wake !== 1'b0) seen++;
        chk("halt wake", 32'h0, 32'(seen));
        @(posedge mclk);
        ext_pin[1] <= 1'b1;
        wake_up(30);
        entry("vector 2", 16'hFFF6, 2'h0);
        entry("vector 5", 16'hFFF0, 2'h3);
        apb(0, NPIC_OFF_STAT, 0);
        chk("edge latch", 32'h0, rd & 32'h4);
        drop(5);
        ext_pin[1] <= 1'b0;
        cpu.do_cc(1, 2'h0);
        cpu.do_cc(1, 2'h2);
    endtask

    // main sequence
    initial begin
        {reset_n, psel, penable, pwrite, slow} = '0;
        paddr = '0;
        pwdata = '0;
        ext_pin = '0;
        per_flag = '0;
        per_clr = '0;
        per_en = '1;
        mismatches = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(negedge mclk);
        chk("reset load", 32'h1, {31'h0, vload});
        chk("reset vector", {16'h0, NPIC_VEC_RESET}, {16'h0, vaddr});
        chk("reset level", 32'h3, {30'h0, ph, pl});
        chk("reset push", 32'h0, 32'(pushes));
        t_regs;
        t_periph;
        t_arb;
        t_conc;
        t_trap;
        t_ext;
        test_done;
    end

    // watchdog
    initial begin
        #1000000;
        mismatches++;
        test_done;
    end
endmodule // tb_npic_ctrl
